/* rtl/pmc_consts.svh */
// constants of the power mode and misc control block
// assumes byte addressing on a 32-bit apb, one register per aligned word
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH

`define PMC_MISC_ADDR 12'h020
`define PMC_STAT_ADDR 12'h024
`define PMC_MISC_RESET 8'h00

// misc control field positions
`define PMC_SLOW_SEL 0
`define PMC_PSM_LO 1
`define PMC_PSM_HI 2
`define PMC_POL_LOWER_LO 3
`define PMC_POL_LOWER_HI 4
`define PMC_CLKOUT_EN 5
`define PMC_POL_UPPER_LO 6
`define PMC_POL_UPPER_HI 7

// halt restart delay, in cpu clock cycles
`define PMC_STAB_CYCLES 4096
`define PMC_STAB_W 13

// half periods of the cpu clock in oscillator cycles
`define PMC_HALF_NORMAL 5'h01
`define PMC_HALF_DIV4 5'h02
`define PMC_HALF_DIV8 5'h04
`define PMC_HALF_DIV16 5'h08
`define PMC_HALF_DIV32 5'h10

// polarity codes, upper bit then lower bit of each field
`define PMC_POL_FALL_LOW 2'h0
`define PMC_POL_RISE 2'h1
`define PMC_POL_FALL 2'h2
`define PMC_POL_BOTH 2'h3

`define PMC_NUM_LINES 4
`define PMC_PINS_PER_LINE 4

`endif

/* rtl/pmc_pkg.sv */
// types of the power mode and misc control block
// assumes pmc_consts.svh is on the include path
`include "pmc_consts.svh"

package pmc_pkg;

  typedef enum logic [1:0] {
    PMC_RUN,
    PMC_WAIT,
    PMC_HALT,
    PMC_STAB
  } pmc_mode_t;

  // per line: pins grouped on one external interrupt vector
  typedef struct packed {
    logic [15:0] level;
    logic [15:0] dir_out;
    logic [15:0] irq_opt;
  } pmc_pins_t;

  typedef struct packed {
    logic wait_instr;
    logic halt_instr;
    logic wdg_enabled;
    logic any_irq;
    logic [3:0] ext_irq_ack;
    logic cc_pop;
  } pmc_cpu_req_t;

  typedef struct packed {
    pmc_mode_t mode;
    logic [7:0] misc;
    logic imask;
    logic [4:0] half;
    logic [4:0] div_cnt;
    logic clk_lvl;
    logic clk_en;
    logic [12:0] stab_cnt;
    logic [15:0] sync1;
    logic [15:0] sync2;
    logic [3:0] grp_prev;
    logic [3:0] pend;
    logic [31:0] prdata;
    logic pslverr;
    logic wdg_rst;
  } pmc_state_t;

endpackage

/* rtl/pmc_top.sv */
// power mode and misc control: cpu clock divider, wait/halt sequencing,
// external interrupt polarity and detection, clock-out pin, apb registers
// assumes pclk is the oscillator and the cpu core drives the instruction
// strobes from logic on pclk; port pin levels come from outside and are
// synchronised here
//
// Local design decision: the APB register port.
`include "pmc_consts.svh"

module pmc_top #(
  parameter int STAB_CYCLES = `PMC_STAB_CYCLES
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu core
  input wire pmc_pkg::pmc_cpu_req_t cpu_req,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic cpu_hold,
  output logic imask,
  output logic osc_enable,
  output logic wdg_reset_req,
  // external interrupt pins
  input wire pmc_pkg::pmc_pins_t pins,
  output logic [3:0] ext_irq_req,
  // clock out pin and its general purpose use
  input wire logic gpio_out,
  input wire logic gpio_oe,
  output logic clock_out_pin_o,
  output logic clock_out_pin_oe
);

  localparam logic [12:0] STAB_LAST = 13'(STAB_CYCLES - 1);

  pmc_pkg::pmc_state_t st;
  pmc_pkg::pmc_state_t next_st;

  // half period of the cpu clock for a given slow select and prescale
  function automatic logic [4:0] half_of(input logic slow, input logic [1:0] psm);
    logic [4:0] h;
    h = `PMC_HALF_NORMAL;
    if (slow) begin
      unique case (psm)
        2'h0: h = `PMC_HALF_DIV4;
        2'h1: h = `PMC_HALF_DIV16;
        2'h2: h = `PMC_HALF_DIV8;
        2'h3: h = `PMC_HALF_DIV32;
      endcase
    end
    return h;
  endfunction

  // polarity field of a line
  function automatic logic [1:0] pol_of(input logic [7:0] m, input int line);
    logic [1:0] p;
    if (line >= 2) begin
      p = {m[`PMC_POL_UPPER_HI], m[`PMC_POL_UPPER_LO]};
    end else begin
      p = {m[`PMC_POL_LOWER_HI], m[`PMC_POL_LOWER_LO]};
    end
    return p;
  endfunction

  // register decode, shared by the write strobe, the read capture and the error response
  function automatic logic hits_misc(input logic [11:0] a);
    return a == `PMC_MISC_ADDR;
  endfunction

  function automatic logic hits_stat(input logic [11:0] a);
    return a == `PMC_STAT_ADDR;
  endfunction

  // refused: anything but the misc and status words, and writes to the read-only status word
  function automatic logic refused(input logic [11:0] a, input logic w);
    logic bad;
    bad = 1'b1;
    if (hits_misc(a)) begin
      bad = 1'b0;
    end else if (hits_stat(a) && !w) begin
      bad = 1'b0;
    end
    return bad;
  endfunction

  // status word: line requests, oscillator, mask, clock level, div32, mode
  function automatic logic [31:0] status_word(input logic [3:0] req, input logic osc,
                                              input pmc_pkg::pmc_state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[1:0] = s.mode;
    w[2] = s.half[4];
    w[3] = s.clk_lvl;
    w[4] = s.imask;
    w[5] = osc;
    w[9:6] = req;
    return w;
  endfunction

  // event selected by a polarity code
  function automatic logic event_of(input logic [1:0] pol, input logic rise,
                                    input logic fall);
    logic e;
    e = 1'b0;
    // falling edge plus low level latches the edge here; the level part is added outside
    unique case (pol)
      `PMC_POL_FALL_LOW: e = fall;
      `PMC_POL_RISE: e = rise;
      `PMC_POL_FALL: e = fall;
      `PMC_POL_BOTH: e = rise | fall;
    endcase
    return e;
  endfunction

  // combined level of each line, and whether any pin feeds it
  logic [3:0] grp_lvl;
  logic [3:0] grp_live;
  logic [3:0] grp_event;
  logic [3:0] grp_low;
  logic [15:0] pin_irq;

  assign pin_irq = pins.irq_opt & ~pins.dir_out;

  genvar g;
  generate
    for (g = 0; g < `PMC_NUM_LINES; g++) begin : g_line
      logic [3:0] en;
      logic [3:0] lv;
      logic [1:0] pol;
      logic rise;
      logic fall;
      assign en = pin_irq[g*4 +: 4];
      assign lv = st.sync2[g*4 +: 4];
      // a pin not feeding the line counts as high, so a low pin masks the rest
      assign grp_lvl[g] = &(lv | ~en);
      assign grp_live[g] = |en;
      assign pol = pol_of(st.misc, g);
      assign rise = grp_live[g] & grp_lvl[g] & ~st.grp_prev[g];
      assign fall = grp_live[g] & ~grp_lvl[g] & st.grp_prev[g];
      assign grp_event[g] = event_of(pol, rise, fall);
      assign grp_low[g] = (pol == `PMC_POL_FALL_LOW) & grp_live[g] & ~grp_lvl[g];
    end
  endgenerate

  // level requests last while the line is low, edge requests stay latched
  assign ext_irq_req = st.pend | grp_low;

  logic setup;
  logic wr_misc;
  logic [7:0] new_misc;
  logic [3:0] pol_chg;

  assign setup = psel & ~penable;
  // apb writes take effect on the access edge
  assign wr_misc = psel & penable & pwrite & hits_misc(paddr);
  assign new_misc = pwdata[7:0];

  // a change to either bit of a field drops the pending requests of both its lines
  generate
    for (g = 0; g < `PMC_NUM_LINES; g++) begin : g_chg
      assign pol_chg[g] = wr_misc & (pol_of(new_misc, g) != pol_of(st.misc, g));
    end
  endgenerate

  always_comb begin
    logic period_end;
    logic osc_on;
    next_st = st;
    period_end = 1'b0;
    osc_on = (st.mode != pmc_pkg::PMC_HALT);
    next_st.clk_en = 1'b0;
    next_st.wdg_rst = 1'b0;
    next_st.pslverr = 1'b0;

    // pins are asynchronous; only the second stage is looked at
    next_st.sync1 = pins.level;
    next_st.sync2 = st.sync1;
    next_st.grp_prev = grp_lvl;

    // pending edge requests: set wins over the clears
    next_st.pend = (st.pend & ~(cpu_req.ext_irq_ack | pol_chg)) | grp_event;

    // divider runs only while the oscillator is on
    if (osc_on) begin
      if (st.div_cnt == st.half - 5'h01) begin
        next_st.div_cnt = 5'h00;
        next_st.clk_lvl = ~st.clk_lvl;
        if (!st.clk_lvl) begin
          next_st.clk_en = 1'b1;
        end else begin
          period_end = 1'b1;
        end
      end else begin
        next_st.div_cnt = st.div_cnt + 5'h01;
      end
    end
    // new rate is picked up only at a period boundary, so no phase is cut
    if (period_end) begin
      next_st.half = half_of(st.misc[`PMC_SLOW_SEL],
                             st.misc[`PMC_PSM_HI:`PMC_PSM_LO]);
    end

    // interrupt mask: set on service entry, cleared by cc pop
    if (|cpu_req.ext_irq_ack) begin
      next_st.imask = 1'b1;
    end else if (cpu_req.cc_pop) begin
      next_st.imask = 1'b0;
    end

    unique case (st.mode)
      pmc_pkg::PMC_RUN: begin
        if (cpu_req.halt_instr && cpu_req.wdg_enabled) begin
          next_st.wdg_rst = 1'b1;
        end else if (cpu_req.halt_instr) begin
          next_st.mode = pmc_pkg::PMC_HALT;
          next_st.imask = 1'b0;
          next_st.clk_lvl = 1'b0;
          next_st.div_cnt = 5'h00;
          // a pulse launched on the entry edge would clock the peripherals in halt
          next_st.clk_en = 1'b0;
        end else if (cpu_req.wait_instr) begin
          next_st.mode = pmc_pkg::PMC_WAIT;
          next_st.imask = 1'b0;
        end
      end
      pmc_pkg::PMC_WAIT: begin
        // the cpu then fetches the vector of the waking source
        if (cpu_req.any_irq || (|ext_irq_req)) begin
          next_st.mode = pmc_pkg::PMC_RUN;
        end
      end
      pmc_pkg::PMC_HALT: begin
        // only external lines wake from halt; reset is handled by presetn
        if (|ext_irq_req) begin
          next_st.mode = pmc_pkg::PMC_STAB;
          next_st.stab_cnt = 13'h0000;
        end
      end
      pmc_pkg::PMC_STAB: begin
        // counted in cpu clock periods, so a slow setting lengthens the delay
        if (st.clk_en) begin
          if (st.stab_cnt == STAB_LAST) begin
            next_st.mode = pmc_pkg::PMC_RUN;
          end else begin
            next_st.stab_cnt = st.stab_cnt + 13'h0001;
          end
        end
      end
    endcase

    if (wr_misc) begin
      next_st.misc = new_misc;
    end

    // read data is captured in the setup phase so it leaves a flop
    if (setup) begin
      next_st.prdata = 32'h0000_0000;
      if (hits_misc(paddr)) begin
        next_st.prdata = {24'h00_0000, st.misc};
      end else if (hits_stat(paddr)) begin
        next_st.prdata = status_word(ext_irq_req, osc_on, st);
      end
      next_st.pslverr = refused(paddr, pwrite);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // reset restarts the oscillator, so the cpu waits out the startup delay
      st.mode <= pmc_pkg::PMC_STAB;
      st.misc <= `PMC_MISC_RESET;
      st.imask <= 1'b1;
      st.half <= `PMC_HALF_NORMAL;
      st.div_cnt <= 5'h00;
      st.clk_lvl <= 1'b0;
      st.clk_en <= 1'b0;
      st.stab_cnt <= 13'h0000;
      st.sync1 <= 16'hffff;
      st.sync2 <= 16'hffff;
      // pins idle high, so starting high avoids a false edge after reset
      st.grp_prev <= 4'hf;
      st.pend <= 4'h0;
      st.prdata <= 32'h0000_0000;
      st.pslverr <= 1'b0;
      st.wdg_rst <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & st.pslverr;

  // one enable drives both cpu and peripherals, so slow mode slows both
  assign periph_clk_en = st.clk_en;
  logic cpu_running;

  assign cpu_running = (st.mode == pmc_pkg::PMC_RUN);
  assign cpu_clk_en = st.clk_en & cpu_running;
  assign cpu_hold = ~cpu_running;
  assign imask = st.imask;
  assign osc_enable = (st.mode != pmc_pkg::PMC_HALT);
  assign wdg_reset_req = st.wdg_rst;

  assign clock_out_pin_o = st.misc[`PMC_CLKOUT_EN] ? st.clk_lvl : gpio_out;
  assign clock_out_pin_oe = st.misc[`PMC_CLKOUT_EN] | gpio_oe;

endmodule

/* tb/pmc_top_sva.sv */
// checker for pmc_top, sees only its ports
// assumes a shadow of the misc register can be kept from apb writes
module pmc_top_sva #(
  parameter int STAB_CYCLES = 4096
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // cpu core
  input wire pmc_pkg::pmc_cpu_req_t cpu_req,
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic cpu_hold,
  input wire logic imask,
  input wire logic osc_enable,
  input wire logic wdg_reset_req,
  // pins
  input wire logic [3:0] ext_irq_req,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  input wire logic clock_out_pin_o,
  input wire logic clock_out_pin_oe
);
  logic [7:0] sh;
  logic wr;
  assign wr = psel && penable && pwrite && paddr == 12'h020;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) sh <= 8'h00;
    else if (wr) sh <= pwdata[7:0];
  // cycles since the last misc write; a new rate is in force once it saturates
  logic [6:0] age;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) age <= 7'h00;
    else if (wr) age <= 7'h00;
    else if (!age[6]) age <= age + 7'h01;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_wait_entry: assert property (cpu_req.wait_instr && !cpu_hold |=>
    cpu_hold && !imask && osc_enable) else $error("wait entry wrong");
  chk_halt_entry: assert property (cpu_req.halt_instr && !cpu_hold &&
    !cpu_req.wdg_enabled |=> cpu_hold && !osc_enable && !imask) else $error("halt entry wrong");
  chk_halt_wdg: assert property (cpu_req.halt_instr && !cpu_hold &&
    cpu_req.wdg_enabled |=> wdg_reset_req && osc_enable) else $error("no watchdog reset");
  chk_halt_clocks: assert property (!osc_enable |->
    !periph_clk_en && !cpu_clk_en) else $error("clock in halt");
  chk_hold_cpu: assert property (cpu_hold |-> !cpu_clk_en) else $error("cpu clocked");
  chk_slow_div32: assert property (periph_clk_en && sh[2:0] == 3'h7 && age[6] |=>
    !periph_clk_en [*8]) else $error("div32 pulse early");
  chk_pol_clear: assert property (wr && pwdata[4:3] != sh[4:3] &&
    pwdata[4:3] != 2'h0 |=> ext_irq_req[1:0] == 2'h0) else $error("pending kept");
  chk_clkout_mux: assert property (sh[5] ? clock_out_pin_oe :
    (clock_out_pin_oe == gpio_oe && clock_out_pin_o == gpio_out)) else $error("pin mux");
  chk_ack_mask: assert property (|cpu_req.ext_irq_ack |=> imask) else $error("mask clear");
endmodule

bind pmc_top pmc_top_sva #(.STAB_CYCLES(STAB_CYCLES)) i_pmc_top_sva (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .cpu_req(cpu_req), .cpu_clk_en(cpu_clk_en),
  .periph_clk_en(periph_clk_en), .cpu_hold(cpu_hold), .imask(imask),
  .osc_enable(osc_enable), .wdg_reset_req(wdg_reset_req), .ext_irq_req(ext_irq_req),
  .gpio_out(gpio_out), .gpio_oe(gpio_oe), .clock_out_pin_o(clock_out_pin_o),
  .clock_out_pin_oe(clock_out_pin_oe));

/* tb/pmc_cpu_model.sv */
// cpu core stand-in: instruction pulses on command, service entry
// assumes the bench issues one command at a time, on pclk
module pmc_cpu_model (
  // clock and commands
  input wire logic pclk,
  input wire logic do_wait,
  input wire logic do_halt,
  input wire logic do_pop,
  input wire logic wdg_on,
  input wire logic irq_in,
  // block side
  input wire logic cpu_hold,
  input wire logic imask,
  input wire logic [3:0] ext_irq_req,
  output pmc_pkg::pmc_cpu_req_t cpu_req
);
  initial cpu_req = '0;
  always @(posedge pclk) begin
    cpu_req.wait_instr <= do_wait;
    cpu_req.halt_instr <= do_halt;
    cpu_req.cc_pop <= do_pop;
    cpu_req.wdg_enabled <= wdg_on;
    cpu_req.any_irq <= irq_in | (|ext_irq_req);
    // one entry per request; the ack of last cycle is still in flight
    cpu_req.ext_irq_ack <= (!cpu_hold && !imask && !(|cpu_req.ext_irq_ack)) ?
      ext_irq_req & (~ext_irq_req + 4'h1) : 4'h0;
  end
endmodule

/* tb/test_power_mode_and_misc_control.sv */
// bench for pmc_top with a cpu stand-in; pins and apb driven here
// assumes STAB_CYCLES shortened to keep the run brief
module test_power_mode_and_misc_control;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(n, e, g) begin checked++; if ((e) !== (g)) begin num_errors++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
  localparam int STB = 8;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, gpio_out = 0, gpio_oe = 0;
  logic do_wait = 0, do_halt = 0, do_pop = 0, wdg_on = 0, irq_in = 0;
  logic pready, pslverr, cpu_clk_en, periph_clk_en, cpu_hold, imask, osc_enable;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, d, exp_q[$];
  logic [3:0] ext_irq_req;
  logic [15:0] lfsr = 16'h0019;
  logic [1:0] p;
  pmc_pkg::pmc_cpu_req_t cpu_req;
  pmc_pkg::pmc_pins_t pins = '{level: 16'hffff, dir_out: 16'h0000, irq_opt: 16'h000f};
  int num_errors = 0, checked = 0, n, c;
  int dv[5] = '{2, 4, 16, 8, 32};
  logic [7:0] md[5] = '{8'h00, 8'h01, 8'h03, 8'h05, 8'h07};
  always #10 pclk = ~pclk;
  pmc_top #(.STAB_CYCLES(STB)) i_pmc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_req(cpu_req), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .cpu_hold(cpu_hold), .imask(imask),
    .osc_enable(osc_enable), .wdg_reset_req(), .pins(pins), .ext_irq_req(ext_irq_req),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .clock_out_pin_o(), .clock_out_pin_oe());
  pmc_cpu_model i_pmc_cpu_model (.pclk(pclk), .do_wait(do_wait), .do_halt(do_halt),
    .do_pop(do_pop), .wdg_on(wdg_on), .irq_in(irq_in), .cpu_hold(cpu_hold), .imask(imask),
    .ext_irq_req(ext_irq_req), .cpu_req(cpu_req));
  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic report_and_stop();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic guard();
    if (++n > 900) begin
      $display("[FAIL] timeout exp done got hang");
      num_errors++;
      report_and_stop();
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin @(posedge pclk); guard(); end while (pready !== 1'b1);
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(0, a, 32'h0);
  endtask
  task automatic pin(input int b, input logic v);
    pins.level[b] <= v;
    repeat (6) @(posedge pclk);
  endtask
  task automatic instr(input logic h);
    if (h) do_halt <= 1; else do_wait <= 1;
    @(posedge pclk);
    do_halt <= 0; do_wait <= 0;
    repeat (4) @(posedge pclk);
  endtask
  task automatic wake();
    n = 0;
    while (cpu_hold !== 1'b0) begin @(posedge pclk); c += periph_clk_en; guard(); end
  endtask
  always @(posedge pclk)
    if (psel && penable && pready) begin
      `CHK("pslverr", paddr != 12'h020 && !(paddr == 12'h024 && !pwrite), pslverr)
      if (!pwrite) `CHK("prdata", exp_q.pop_front(), prdata)
    end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    wake();
    rd(12'h020, 32'h0);
    for (int i = 0; i < 4; i++) begin
      lfsr = step(lfsr);
      gpio_out <= lfsr[8]; gpio_oe <= lfsr[9];
      d = {24'h0, lfsr[7:0]};
      d[5] = i[0];
      apb(1, 12'h020, d);
      rd(12'h020, d);
    end
    rd(12'h040, 32'h0);
    $display("done: registers");
    for (int i = 0; i < 5; i++) begin
      apb(1, 12'h020, {24'h0, md[i]});
      repeat (70) @(posedge pclk);
      n = 0;
      while (cpu_clk_en !== 1'b1) begin @(posedge pclk); guard(); end
      c = 0;
      do begin @(posedge pclk); c++; end while (cpu_clk_en !== 1'b1 && c < 99);
      `CHK("period", dv[i], c)
      `CHK("periph", 1'b1, periph_clk_en)
    end
    $display("done: clock rates");
    for (int k = 1; k < 5; k++) begin
      p = 2'(k);
      apb(1, 12'h020, {27'h0, p, 3'h0});
      `CHK("clear", 1'b0, ext_irq_req[0])
      pin(0, 0);
      `CHK("low", p != 2'h1, ext_irq_req[0])
      pin(0, 1);
      if (p != 2'h0) `CHK("high", 1'b1, ext_irq_req[0])
    end
    apb(1, 12'h020, 32'h10);
    pins.dir_out[1] <= 1;
    pin(1, 0);
    `CHK("output", 1'b0, ext_irq_req[0])
    pins.dir_out[1] <= 0;
    pin(1, 0);
    `CHK("group", 1'b1, ext_irq_req[0])
    apb(1, 12'h020, 32'h18);
    apb(1, 12'h020, 32'h10);
    pin(0, 0);
    pin(0, 1);
    `CHK("masked", 1'b0, ext_irq_req[0])
    pin(1, 1);
    $display("done: polarity");
    instr(1);
    `CHK("halt", 2'b10, {cpu_hold, osc_enable})
    `CHK("imask", 1'b0, imask)
    pins.level[0] <= 0;
    c = 0;
    wake();
    `CHK("restart", STB, c)
    repeat (6) @(posedge pclk);
    `CHK("served", 2'b01, {ext_irq_req[0], imask})
    do_pop <= 1;
    @(posedge pclk);
    do_pop <= 0;
    repeat (3) @(posedge pclk);
    `CHK("pop", 1'b0, imask)
    pin(0, 1);
    instr(0);
    repeat (20) @(posedge pclk);
    `CHK("wait", 2'b11, {cpu_hold, osc_enable})
    irq_in <= 1;
    wake();
    irq_in <= 0;
    wdg_on <= 1;
    instr(1);
    `CHK("wdg", 1'b1, osc_enable)
    $display("done: power modes");
    report_and_stop();
  end
endmodule
